// >>> design/rbu_cond.sv
// rbu_cond: combinational branch condition decoder
// assumes: flags and pin level already registered by the caller
`default_nettype none
module rbu_cond (
    input  wire logic [7:0] opcode,    // fetched opcode
    input  wire logic [4:0] condition_code_register,       // condition code flags
    input  wire logic       irq_pin,   // external interrupt pin level
    input  wire logic       mem_bit,   // tested memory bit
    output logic            is_rel,    // two-byte relative branch
    output logic            is_bit,    // bit-test branch
    output logic            take       // branch condition true
);
    // ****************************************
    // decode
    // ****************************************
    // bit-test class: low nibble odd selects clear form
    function automatic logic bit_zero_op(input logic [7:0] op);
        bit_zero_op = ((op & rbu_pkg::OP_BITTEST_MASK) == rbu_pkg::OP_BITTEST_BASE)
                      && op[0] == rbu_pkg::OP_BIT_ZERO_LSB[0];
    endfunction

    // condition per opcode
    always_comb begin
        is_rel = 1'b1;
        is_bit = 1'b0;
        take   = 1'b0;
        case (opcode)
            rbu_pkg::OP_ALWAYS:      take = 1'b1;
            rbu_pkg::OP_NEVER:       take = 1'b0;
            rbu_pkg::OP_HIGHER:      take = !(condition_code_register[rbu_pkg::CC_C] | condition_code_register[rbu_pkg::CC_Z]);
            rbu_pkg::OP_LOWER_SAME:  take = condition_code_register[rbu_pkg::CC_C] | condition_code_register[rbu_pkg::CC_Z];
            rbu_pkg::OP_CARRY_CLEAR: take = !condition_code_register[rbu_pkg::CC_C];
            rbu_pkg::OP_CARRY_SET:   take = condition_code_register[rbu_pkg::CC_C];
            rbu_pkg::OP_NONZERO:     take = !condition_code_register[rbu_pkg::CC_Z];
            rbu_pkg::OP_ZERO:        take = condition_code_register[rbu_pkg::CC_Z];
            rbu_pkg::OP_HALF_CLEAR:  take = !condition_code_register[rbu_pkg::CC_H];
            rbu_pkg::OP_HALF_SET:    take = condition_code_register[rbu_pkg::CC_H];
            rbu_pkg::OP_POSITIVE:    take = !condition_code_register[rbu_pkg::CC_N];
            rbu_pkg::OP_NEGATIVE:    take = condition_code_register[rbu_pkg::CC_N];
            rbu_pkg::OP_MASK_CLEAR:  take = !condition_code_register[rbu_pkg::CC_I];
            rbu_pkg::OP_MASK_SET:    take = condition_code_register[rbu_pkg::CC_I];
            rbu_pkg::OP_IRQ_LOW:     take = !irq_pin;
            rbu_pkg::OP_IRQ_HIGH:    take = irq_pin;
            default: begin
                // not a two-byte branch
                is_rel = 1'b0;
                if (bit_zero_op(opcode)) begin
                    is_bit = 1'b1;
                    take   = !mem_bit;
                end
            end
        endcase
    end
endmodule
`default_nettype wire

// >>> design/rbu_pkg.sv
// rbu_pkg: constants, types and structs for the relative branch unit
// assumes: included before every other design file of the block
`default_nettype none
package rbu_pkg;
    // ****************************************
    // widths
    // ****************************************
    localparam int unsigned PC_W   = 16;           // program counter width
    localparam int unsigned DATA_W = 8;            // byte width
    localparam int unsigned ADDR_W = 32;           // axi address width
    localparam int unsigned AXI_W  = 32;           // axi data width
    // ****************************************
    // opcodes
    // ****************************************
    localparam logic [7:0] OP_ALWAYS       = 8'h20; // branch_always
    localparam logic [7:0] OP_NEVER        = 8'h21; // branch_never
    localparam logic [7:0] OP_HIGHER       = 8'h22; // branch_if_higher
    localparam logic [7:0] OP_LOWER_SAME   = 8'h23; // branch_if_lower_or_same
    localparam logic [7:0] OP_CARRY_CLEAR  = 8'h24; // branch_if_carry_clear
    localparam logic [7:0] OP_CARRY_SET    = 8'h25; // branch_if_carry_set
    localparam logic [7:0] OP_NONZERO      = 8'h26; // branch_if_nonzero
    localparam logic [7:0] OP_ZERO         = 8'h27; // branch_if_zero
    localparam logic [7:0] OP_HALF_CLEAR   = 8'h28; // branch_if_half_carry_clear
    localparam logic [7:0] OP_HALF_SET     = 8'h29; // branch_if_half_carry_set
    localparam logic [7:0] OP_POSITIVE     = 8'h2A; // branch_if_positive
    localparam logic [7:0] OP_NEGATIVE     = 8'h2B; // branch_if_negative
    localparam logic [7:0] OP_MASK_CLEAR   = 8'h2C; // branch_if_mask_clear
    localparam logic [7:0] OP_MASK_SET     = 8'h2D; // branch_if_mask_set
    localparam logic [7:0] OP_IRQ_LOW      = 8'h2E; // branch_if_irq_pin_low
    localparam logic [7:0] OP_IRQ_HIGH     = 8'h2F; // branch_if_irq_pin_high
    localparam logic [7:0] OP_BIT_ZERO_LSB = 8'h01; // branch_if_bit_zero, n=0
    localparam logic [7:0] OP_BITTEST_MASK = 8'hF0; // bit-test class occupies 0x
    localparam logic [7:0] OP_BITTEST_BASE = 8'h00; // bit-test class prefix
    // ****************************************
    // lengths and cycle counts
    // ****************************************
    localparam logic [PC_W-1:0] LEN_REL    = 16'h0002; // opcode + offset
    localparam logic [PC_W-1:0] LEN_BIT    = 16'h0003; // opcode + addr + offset
    localparam logic [3:0]      CYC_REL    = 4'h3;     // two-byte branch cycles
    localparam logic [3:0]      CYC_BIT    = 4'h5;     // bit-test branch cycles
    localparam logic [7:0]      DIRECT_HI  = 8'h00;    // direct page high byte
    // ****************************************
    // condition code bit positions
    // ****************************************
    localparam int unsigned CC_C = 0;              // carry
    localparam int unsigned CC_Z = 1;              // zero
    localparam int unsigned CC_N = 2;              // negative
    localparam int unsigned CC_I = 3;              // interrupt mask
    localparam int unsigned CC_H = 4;              // half carry
    localparam logic [4:0]  CC_RESET = 5'h08;      // mask set after reset
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [ADDR_W-1:0] REG_CTRL   = 32'h0000_0000; // opcode addr, start
    localparam logic [ADDR_W-1:0] REG_CCR    = 32'h0000_0004; // condition_code_register
    localparam logic [ADDR_W-1:0] REG_STATUS = 32'h0000_0008; // busy, taken, done, illegal
    localparam logic [ADDR_W-1:0] REG_NEXTPC = 32'h0000_000C; // resulting pc
    localparam int unsigned CTRL_START  = 16;      // start bit in control word
    localparam int unsigned ST_BUSY     = 0;       // status busy bit
    localparam int unsigned ST_TAKEN    = 1;       // status taken bit
    localparam int unsigned ST_DONE     = 2;       // status done bit, sticky
    localparam int unsigned ST_ILLEGAL  = 3;       // status non-branch opcode
    localparam logic [1:0]  RESP_OKAY   = 2'h0;    // axi okay
    localparam logic [1:0]  RESP_SLVERR = 2'h2;    // axi slave error
    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic             req;                     // fetch request
        logic [PC_W-1:0]  addr;                    // fetch address
    } rbu_fetch_s;
    typedef struct packed {
        logic             valid;                   // byte returned
        logic [DATA_W-1:0] data;                   // byte value
    } rbu_byte_s;
    typedef enum logic [2:0] {
        ST_IDLE, ST_OPC, ST_ARG1, ST_ARG2, ST_MEM, ST_WAIT
    } rbu_state_e;
endpackage
`default_nettype wire

// >>> design/rbu_target.sv
// rbu_target: relative branch target adder
// assumes: offset byte is the last byte of the instruction
`default_nettype none
module rbu_target (
    input  wire logic [15:0] op_addr,  // opcode address
    input  wire logic [15:0] length,   // instruction length
    input  wire logic [7:0]  offset,   // signed offset byte
    input  wire logic        take,     // branch taken
    output logic [15:0]      next_pc   // resulting pc
);
    // ****************************************
    // adder
    // ****************************************
    logic [15:0] seq_pc;               // sequential successor
    logic [15:0] sext;                 // sign-extended offset

    // wraps mod 2^16, no saturation
    always_comb begin
        seq_pc  = op_addr + length;
        sext    = {{8{offset[7]}}, offset};
        next_pc = take ? 16'(seq_pc + sext) : seq_pc;
    end
endmodule
`default_nettype wire

// >>> design/rbu_top.sv
// rbu_top: relative branch unit with fetch sequencer and axi4-lite registers
// assumes: program memory answers a byte request with mem_valid one or more cycles later
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`default_nettype none
module rbu_top (
    input  wire logic        aclk,          // core clock
    input  wire logic        aresetn,       // sync reset, low active
    input  wire logic        irq_pin,       // external interrupt pin level
    output logic             mem_req,       // program memory read request
    output logic [15:0]      mem_addr,      // program memory address
    input  wire logic        mem_valid,     // read data valid
    input  wire logic [7:0]  mem_rdata,     // read data
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // ****************************************
    // state
    // ****************************************
    rbu_pkg::rbu_state_e st_q, st_d;        // sequencer state
    logic [15:0] pc_q, pc_d;                // opcode address
    logic [7:0]  op_q, op_d;                // captured opcode
    logic        mbit_q, mbit_d;            // tested memory bit
    logic [4:0]  ccr_q, ccr_d;              // condition flags
    logic [3:0]  cyc_q, cyc_d;              // cycles since start
    logic [3:0]  need_q, need_d;            // cycles the instruction needs
    logic [15:0] npc_q, npc_d;              // result pc
    logic        taken_q, taken_d;          // last result taken
    logic        done_q, done_d;            // sticky done flag
    logic        ill_q, ill_d;              // non-branch opcode seen
    logic        req_q, req_d;              // memory request
    logic [15:0] maddr_q, maddr_d;          // memory address
    logic        irq_q;                     // registered pin level
    rbu_pkg::rbu_fetch_s fetch;             // request view
    rbu_pkg::rbu_byte_s  rbyte;             // returned byte
    logic        is_rel, is_bit, take;      // decoder outputs
    logic [15:0] target;                    // adder output
    logic        start, clr_done;           // software strobes
    logic [15:0] start_pc;                  // software opcode address
    logic [4:0]  ccr_wr;                    // software flag write
    logic        ccr_we;                    // flag write enable

    assign rbyte = '{valid: mem_valid, data: mem_rdata};
    assign fetch = '{req: req_q, addr: maddr_q};
    assign mem_req  = fetch.req;
    assign mem_addr = fetch.addr;

    // ****************************************
    // submodules
    // ****************************************
    rbu_cond u_cond (
        .opcode  (op_q),
        .condition_code_register     (ccr_q),
        .irq_pin (irq_q),
        .mem_bit (mbit_q),
        .is_rel  (is_rel),
        .is_bit  (is_bit),
        .take    (take)
    );
    rbu_target u_target (
        .op_addr (pc_q),
        .length  (is_bit ? rbu_pkg::LEN_BIT : rbu_pkg::LEN_REL),
        .offset  (rbyte.data),
        .take    (take),
        .next_pc (target)
    );

    // ****************************************
    // sequencer
    // ****************************************
    // next state for fetch, decode and result
    always_comb begin
        st_d = st_q; pc_d = pc_q; op_d = op_q; mbit_d = mbit_q;
        ccr_d = ccr_we ? ccr_wr : ccr_q;
        cyc_d = (st_q == rbu_pkg::ST_IDLE) ? 4'h0 : 4'(cyc_q + 4'h1);
        need_d = need_q; npc_d = npc_q; taken_d = taken_q;
        done_d = clr_done ? 1'b0 : done_q;
        ill_d = ill_q; req_d = 1'b0; maddr_d = maddr_q;
        case (st_q)
            rbu_pkg::ST_IDLE: begin
                // start fetch of opcode
                if (start) begin
                    pc_d = start_pc; maddr_d = start_pc; req_d = 1'b1;
                    ill_d = 1'b0; st_d = rbu_pkg::ST_OPC;
                end
            end
            rbu_pkg::ST_OPC: begin
                // opcode arrives, fetch next byte
                if (rbyte.valid) begin
                    op_d = rbyte.data; req_d = 1'b1; maddr_d = 16'(pc_q + 16'h0001);
                    st_d = rbu_pkg::ST_ARG1;
                end
            end
            rbu_pkg::ST_ARG1: begin
                if (rbyte.valid) begin
                    if (is_rel) begin
                        // offset byte, result ready
                        npc_d = target; taken_d = take;
                        need_d = rbu_pkg::CYC_REL; st_d = rbu_pkg::ST_WAIT;
                    end else if (is_bit) begin
                        // direct address, read page zero
                        req_d = 1'b1;
                        maddr_d = {rbu_pkg::DIRECT_HI, rbyte.data};
                        st_d = rbu_pkg::ST_MEM;
                    end else begin
                        // not a branch: flag and stop
                        ill_d = 1'b1; npc_d = pc_q; taken_d = 1'b0;
                        need_d = 4'h0; st_d = rbu_pkg::ST_WAIT;
                    end
                end
            end
            rbu_pkg::ST_MEM: begin
                // tested bit, then offset after address byte
                if (rbyte.valid) begin
                    mbit_d = rbyte.data[op_q[3:1]];
                    ccr_d[rbu_pkg::CC_C] = rbyte.data[op_q[3:1]];
                    req_d = 1'b1; maddr_d = 16'(pc_q + 16'h0002);
                    st_d = rbu_pkg::ST_ARG2;
                end
            end
            rbu_pkg::ST_ARG2: begin
                if (rbyte.valid) begin
                    npc_d = target; taken_d = take;
                    need_d = rbu_pkg::CYC_BIT; st_d = rbu_pkg::ST_WAIT;
                end
            end
            rbu_pkg::ST_WAIT: begin
                // pad to the documented cycle count
                if (cyc_q >= 4'(need_q - 4'h1)) begin
                    done_d = 1'b1; st_d = rbu_pkg::ST_IDLE;
                end
            end
            default: st_d = rbu_pkg::ST_IDLE;
        endcase
    end

    // registers of the sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= rbu_pkg::ST_IDLE; pc_q <= 16'h0000; op_q <= 8'h00;
            mbit_q <= 1'b0; ccr_q <= rbu_pkg::CC_RESET; cyc_q <= 4'h0; need_q <= 4'h0;
            npc_q <= 16'h0000; taken_q <= 1'b0; done_q <= 1'b0; ill_q <= 1'b0;
            req_q <= 1'b0; maddr_q <= 16'h0000; irq_q <= 1'b0;
        end else begin
            st_q <= st_d; pc_q <= pc_d; op_q <= op_d;
            mbit_q <= mbit_d; ccr_q <= ccr_d; cyc_q <= cyc_d; need_q <= need_d;
            npc_q <= npc_d; taken_q <= taken_d; done_q <= done_d; ill_q <= ill_d;
            req_q <= req_d; maddr_q <= maddr_d; irq_q <= irq_pin;
        end
    end

    // ****************************************
    // axi4-lite slave
    // ****************************************
    logic        aw_q, aw_d, w_q, w_d, b_q, b_d, ar_q, ar_d, r_q, r_d;
    logic [31:0] awa_q, awa_d, wd_q, wd_d, rd_q, rd_d;
    logic [3:0]  ws_q, ws_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;
    logic        wfire;                     // both halves held

    // write and read channel handling
    always_comb begin
        aw_d = aw_q; w_d = w_q; awa_d = awa_q; wd_d = wd_q; ws_d = ws_q;
        b_d = b_q; br_d = br_q; ar_d = 1'b0; r_d = r_q; rd_d = rd_q; rr_d = rr_q;
        start = 1'b0; clr_done = 1'b0; ccr_we = 1'b0; ccr_wr = ccr_q;
        start_pc = wd_q[15:0];
        if (!aw_q && s_axi_awvalid && !b_q) begin aw_d = 1'b1; awa_d = s_axi_awaddr; end
        if (!w_q && s_axi_wvalid && !b_q) begin w_d = 1'b1; wd_d = s_axi_wdata; ws_d = s_axi_wstrb; end
        wfire = aw_q && w_q && !b_q;
        if (wfire) begin
            aw_d = 1'b0; w_d = 1'b0; b_d = 1'b1; br_d = rbu_pkg::RESP_OKAY;
            case (awa_q[7:0])
                rbu_pkg::REG_CTRL[7:0]:
                    start = ws_q[2] && wd_q[rbu_pkg::CTRL_START] && st_q == rbu_pkg::ST_IDLE;
                rbu_pkg::REG_CCR[7:0]: begin
                    ccr_we = ws_q[0] && st_q == rbu_pkg::ST_IDLE; ccr_wr = wd_q[4:0];
                end
                rbu_pkg::REG_STATUS[7:0]: clr_done = ws_q[0] && wd_q[rbu_pkg::ST_DONE];
                rbu_pkg::REG_NEXTPC[7:0]: ;
                default: br_d = rbu_pkg::RESP_SLVERR;
            endcase
            if (awa_q[31:8] != 24'h0) br_d = rbu_pkg::RESP_SLVERR;
        end
        if (b_q && s_axi_bready) b_d = 1'b0;
        if (r_q && s_axi_rready) r_d = 1'b0;
        if (!r_q && !ar_q && s_axi_arvalid) begin
            ar_d = 1'b1; r_d = 1'b1; rr_d = rbu_pkg::RESP_OKAY; rd_d = 32'h0000_0000;
            case (s_axi_araddr)
                rbu_pkg::REG_CTRL:   rd_d = {16'h0000, pc_q};
                rbu_pkg::REG_CCR:    rd_d = {27'h0, ccr_q};
                rbu_pkg::REG_STATUS: rd_d = {28'h0, ill_q, done_q, taken_q, st_q != rbu_pkg::ST_IDLE};
                rbu_pkg::REG_NEXTPC: rd_d = {16'h0000, npc_q};
                default:             rr_d = rbu_pkg::RESP_SLVERR;
            endcase
        end
    end

    // axi registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b0; ar_q <= 1'b0; r_q <= 1'b0;
            awa_q <= 32'h0; wd_q <= 32'h0; ws_q <= 4'h0; rd_q <= 32'h0;
            br_q <= 2'h0; rr_q <= 2'h0;
        end else begin
            aw_q <= aw_d; w_q <= w_d; b_q <= b_d; ar_q <= ar_d; r_q <= r_d;
            awa_q <= awa_d; wd_q <= wd_d; ws_q <= ws_d; rd_q <= rd_d;
            br_q <= br_d; rr_q <= rr_d;
        end
    end

    assign s_axi_awready = aw_d && !aw_q;
    assign s_axi_wready  = w_d && !w_q;
    assign s_axi_bvalid  = b_q;
    assign s_axi_bresp   = br_q;
    assign s_axi_arready = ar_q;
    assign s_axi_rvalid  = r_q;
    assign s_axi_rdata   = rd_q;
    assign s_axi_rresp   = rr_q;
endmodule
`default_nettype wire

// >>> tb/rbu_prog_mem.sv
// rbu_prog_mem: program memory answering each fetch once, after one or three cycles
// assumes: one request outstanding; the bench fills the byte array directly
`default_nettype none
module rbu_prog_mem (
    input  wire logic        aclk,      // core clock
    input  wire logic        slow,      // answer after three cycles
    input  wire logic        mem_req,   // fetch request
    input  wire logic [15:0] mem_addr,  // fetch address
    output logic             mem_valid, // byte returned
    output logic [7:0]       mem_rdata  // byte value
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  bytes [0:65535]; // memory contents
    logic [15:0] addr_q;          // latched request address
    int          wait_q = 0;      // cycles left before answer
    always @(posedge aclk) begin // one answer per request
        mem_valid <= 1'b0;
        mem_rdata <= ~mem_rdata; // idle data keeps toggling
        if (mem_req) begin
            addr_q <= mem_addr;
            wait_q <= slow ? 3 : 1;
        end else if (wait_q == 1) begin
            mem_valid <= 1'b1;
            mem_rdata <= bytes[addr_q];
            wait_q <= 0;
        end else if (wait_q > 1) wait_q <= wait_q - 1;
    end
endmodule
`default_nettype wire

// >>> tb/rbu_top_checker.sv
// rbu_top_checker: fetch order and register handshake properties of rbu_top
// assumes: one aclk domain; bound to every rbu_top instance
`default_nettype none
module rbu_top_checker (
    input wire logic        aclk, aresetn, mem_req, mem_valid, s_axi_awvalid, s_axi_awready,
    input wire logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0]  mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [1:0]  rem_q, rem_d; // bytes still owed to this instruction
    logic [15:0] opa_q, opa_d; // opcode address of this instruction
    always_comb begin // follow instruction boundaries from returned bytes
        opa_d = (mem_req && rem_q == 2'h0) ? mem_addr : opa_q;
        rem_d = !mem_valid ? rem_q : (rem_q != 2'h0) ? rem_q - 2'h1 : (mem_rdata[7:4] == 4'h2) ? 2'h1 :
                (mem_rdata[7:4] == 4'h0 && mem_rdata[0]) ? 2'h3 : 2'h0;
    end
    always_ff @(posedge aclk) begin // register trackers
        rem_q <= aresetn ? rem_d : 2'h0;
        opa_q <= opa_d;
    end
    sequence s_rel_opc; mem_valid && rem_q == 2'h0 && mem_rdata[7:4] == 4'h2; endsequence
    sequence s_bit_dir; mem_valid && rem_q == 2'h3; endsequence // direct address byte returned
    a_req_pulse: assert property (mem_req |=> !mem_req) else $error("fetch request too long");
    a_rel_offset: assert property (s_rel_opc |-> ##[1:4] mem_req && mem_addr == opa_q + 16'h0001)
        else $error("offset byte not fetched next");
    a_bit_direct: assert property (s_bit_dir |-> ##1 mem_req && mem_addr == {8'h00, $past(mem_rdata)})
        else $error("operand outside direct page");
    a_bit_offset: assert property (mem_valid && rem_q == 2'h2 |->
        ##[1:4] mem_req && mem_addr == opa_q + 16'h0002) else $error("bit test offset misplaced");
    a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready longer than a cycle");
    a_b_timing: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
        ##2 s_axi_bvalid) else $error("write response late or early");
    a_no_aw_in_b: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken in response");
    a_r_with_ar: assert property (s_axi_arready |-> s_axi_rvalid) else $error("read data not with arready");
endmodule
bind rbu_top rbu_top_checker i_rbu_top_checker (.aclk(aclk), .aresetn(aresetn), .mem_req(mem_req),
    .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire

// >>> tb/rbu_top_tb.sv
// rbu_top_tb: random and corner branch runs driven through the register port
// assumes: rbu_prog_mem answers fetches; checker bound to rbu_top
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin err_total++; $display("BAD %s exp %h got %h", nm, (ex), (gt)); end end
module rbu_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = 1'b0, aresetn = 1'b0, irq_pin = 1'b0, slow = 1'b0, mem_req, mem_valid, b;
    logic [15:0] mem_addr, a;
    logic [7:0]  mem_rdata, op, off, dd, byt;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, d, m;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [4:0]  cc;
    int          err_total = 0, checks = 0, seed = 80523;
    rbu_top i_rbu_top (.aclk, .aresetn, .irq_pin, .mem_req, .mem_addr, .mem_valid, .mem_rdata, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    rbu_prog_mem i_rbu_prog_mem (.aclk, .slow, .mem_req, .mem_addr, .mem_valid, .mem_rdata);
    initial forever #25 aclk = ~aclk; // 20 MHz core clock
    task automatic finish_test(); // verdict and end of run
        if (err_total == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic axw(input logic [31:0] ad, input logic [31:0] wd, output logic [1:0] rs); // one write
        @(posedge aclk); // let an edge pass after the last release
        s_axi_awaddr <= ad; s_axi_wdata <= wd; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [31:0] ad, output logic [31:0] rd, output logic [1:0] rs); // one read
        @(posedge aclk); // let an edge pass after the last release
        s_axi_araddr <= ad; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata; rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    function automatic logic f_take(input logic [7:0] o, input logic [4:0] c, input logic irq, input logic mb);
        logic [7:0] v;
        v = {irq, c[3], c[2], c[4], c[1], c[0], c[0] | c[1], 1'b0}; // condition per opcode pair
        return (o[7:4] == 4'h0) ? ~mb : (v[o[3:1]] ^ ~o[0]);
    endfunction
    function automatic logic [15:0] f_next(input logic [7:0] o, input logic [15:0] pa, input logic [7:0] ofs,
                                           input logic tk);
        logic [15:0] len;
        len = (o[7:4] == 4'h0) ? rbu_pkg::LEN_BIT : rbu_pkg::LEN_REL;
        return tk ? pa + len + {{8{ofs[7]}}, ofs} : pa + len;
    endfunction
    initial begin // watchdog on a hung run
        repeat (30000) @(posedge aclk);
        err_total++;
        finish_test();
    end
    initial begin // reset, register checks, then branch runs
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(rbu_pkg::REG_CCR, d, r);
        `CHK("ccr reset", rbu_pkg::CC_RESET, d[4:0])
        axr(32'h0000_0010, d, r);
        `CHK("unmapped read", rbu_pkg::RESP_SLVERR, r)
        for (int k = 0; k < 68; k++) begin // each two-byte opcode four times plus four random bit tests, corners first
            m = $random(seed);
            op = (k % 17 < 16) ? 8'h20 + 8'(k % 17) : {4'h0, m[2:0], 1'b1};
            cc = m[7:3];
            b = m[8];
            dd = m[16:9] | 8'h10;
            off = (k == 0) ? 8'h7F : (k == 1) ? 8'h80 : m[24:17];
            irq_pin <= m[25];
            slow <= m[26];
            a = (k < 2) ? 16'hFFFE : 16'($random(seed)) | 16'h0100;
            byt = m[31:24];
            byt[op[3:1]] = b;
            i_rbu_prog_mem.bytes[a] = op;
            i_rbu_prog_mem.bytes[16'(a + 16'h0001)] = (op[7:4] == 4'h0) ? dd : off;
            i_rbu_prog_mem.bytes[16'(a + 16'h0002)] = off;
            i_rbu_prog_mem.bytes[{8'h00, dd}] = byt;
            axw(rbu_pkg::REG_CCR, {27'h0, cc}, r);
            axw(rbu_pkg::REG_CTRL, {15'h0, 1'b1, a}, r);
            do begin
                axr(rbu_pkg::REG_STATUS, d, r);
            end while (d[2] !== 1'b1); // a hang ends at the watchdog
            `CHK("taken", f_take(op, cc, irq_pin, b), d[1])
            axr(rbu_pkg::REG_NEXTPC, d, r);
            `CHK("next pc", f_next(op, a, off, f_take(op, cc, irq_pin, b)), d[15:0])
            axr(rbu_pkg::REG_CCR, d, r);
            `CHK("flags", ((op[7:4] == 4'h0) ? {cc[4:1], b} : cc), d[4:0])
            axw(rbu_pkg::REG_STATUS, 32'h0000_0004, r);
        end
        axw(32'h0000_0020, 32'h0000_0000, r);
        `CHK("unmapped write", rbu_pkg::RESP_SLVERR, r)
        finish_test();
    end
endmodule
`default_nettype wire
